// ### inc/pmt_defines.svh
// Shared constants for the program memory table-read unit and its serial link
`ifndef PMT_DEFINES_SVH
`define PMT_DEFINES_SVH

`define PMT_ADDR_W       12
`define PMT_WORD_W       15
`define PMT_BYTE_W       8
`define PMT_HI_BITS      7
`define PMT_DEPTH        4096
`define PMT_RESET_VEC    12'h000
`define PMT_LAST_PAGE    4'hf
`define PMT_CLK_PER_ICYC 4
`define PMT_TBL_ICYC     2
`define PMT_TBL_CLKS     (`PMT_TBL_ICYC * `PMT_CLK_PER_ICYC)
`define PMT_CNT_W        4
`define PMT_BIT_W        5
`define PMT_HDR_BITS     5'h0d
`define PMT_HDR_LAST     5'h0c
`define PMT_LAST_BIT     5'h1b
`define PMT_FRAME_BITS   28
`define PMT_HALF_CLKS    8
`define PMT_TMR_W        8
`define PMT_CMD_WRITE    1'b1
`define PMT_SYNC_W       4

`endif

// ### inc/pmt_pkg.sv
// Types shared by both ends of the program memory unit
`include "pmt_defines.svh"

package pmt_pkg;

  // Table-read sequencer, Gray along idle -> fetch -> done
  typedef enum logic [1:0]
  {
    PMT_TS_IDLE  = 2'b00,
    PMT_TS_FETCH = 2'b01,
    PMT_TS_DONE  = 2'b11
  } pmt_tbl_state_t;

  // Programmer frame sequencer, Gray along idle -> low -> high -> gap
  typedef enum logic [1:0]
  {
    PMT_HS_IDLE = 2'b00,
    PMT_HS_LOW  = 2'b01,
    PMT_HS_HIGH = 2'b11,
    PMT_HS_GAP  = 2'b10
  } pmt_host_state_t;

  typedef logic [`PMT_WORD_W-1:0] pmt_word_t;
  typedef logic [`PMT_ADDR_W-1:0] pmt_addr_t;

endpackage

// ### inc/pmt_link_if.sv
// Serial programming / debug link between the device and the external programmer
`timescale 1ns/1ps
`default_nettype none

interface pmt_link_if;
  logic dev_data_o;
  logic dev_data_oe;
  logic dev_clk_o;
  logic dev_clk_oe;
  logic host_data_o;
  logic host_data_oe;
  logic host_clk_o;
  logic host_clk_oe;
  logic host_entry;
  wire  prog_serial_data;
  wire  prog_serial_clock;
  wire  debug_serial_data;
  wire  debug_serial_clock;

  // Wire levels resolved from the enables; data idles high through a pull-up
  assign prog_serial_data  = dev_data_oe ? dev_data_o :
                             (host_data_oe ? host_data_o : 1'b1);
  assign prog_serial_clock = dev_clk_oe ? dev_clk_o :
                             (host_clk_oe ? host_clk_o : 1'b0);
  // Debug pins are the same physical pins as the programming pins
  assign debug_serial_data  = prog_serial_data;
  assign debug_serial_clock = prog_serial_clock;

  modport device
  (
    output dev_data_o, dev_data_oe, dev_clk_o, dev_clk_oe,
    input  prog_serial_data, prog_serial_clock, host_entry,
    input  debug_serial_data, debug_serial_clock
  );

  modport host
  (
    output host_data_o, host_data_oe, host_clk_o, host_clk_oe, host_entry,
    input  prog_serial_data, prog_serial_clock
  );
endinterface

`default_nettype wire

// ### rtl/pmt_device.sv
// Program memory store, table-read unit and serial programming slave
`timescale 1ns/1ps
`default_nettype none
`include "pmt_defines.svh"

// Overview of operation
// - Store of 4K words, 15 bits each
// - Execution starts at address zero after reset
// - Table address taken from pointers, not counter
// - Low byte written to operand data register
// - Upper bits go to latch, rest zero
// - Latch changes only on table reads
// - Table read lasts two instruction cycles
// - Last-page read ignores high pointer
// - Software avoids table reads in interrupts
// - Serial data one pin, programmer clock
// - Board adds no drivers on programming pins
// - Debug pins driven by external tool
// - Emulation mutes shared pin functions
module pmt_device
  import pmt_pkg::*;
(
  input  wire logic                   CORE_CLK,     // System clock
  input  wire logic                   RST,          // Synchronous reset, active high
  input  wire logic [`PMT_ADDR_W-1:0] CORE_PC,      // Program counter for fetch
  output var  logic [`PMT_WORD_W-1:0] INSTR,        // Fetched word
  output var  logic                   PC_LOAD,      // Pulse: load PC_VECTOR
  output var  logic [`PMT_ADDR_W-1:0] PC_VECTOR,    // Start address
  input  wire logic                   TBL_RD,       // Table-read request
  input  wire logic                   TBL_LAST,     // Last-page variant
  input  wire logic [`PMT_BYTE_W-1:0] TBLP,         // Low table pointer
  input  wire logic [3:0]             TBHP,         // High table pointer
  input  wire logic [`PMT_BYTE_W-1:0] TBL_DEST,     // Operand register address
  output var  logic                   TBL_BUSY,     // Table read in progress
  output var  logic                   DM_WE,        // Data memory write pulse
  output var  logic [`PMT_BYTE_W-1:0] DM_ADDR,      // Data memory address
  output var  logic [`PMT_BYTE_W-1:0] DM_WDATA,     // Data memory write data
  output var  logic [`PMT_BYTE_W-1:0] TABLE_HIGH,   // Table high latch
  input  wire logic                   EMU_MODE,     // Emulation part strap
  input  wire logic                   PIN_DATA_OUT, // Shared function, data pin
  input  wire logic                   PIN_DATA_OE,  // Shared function enable
  input  wire logic                   PIN_CLK_OUT,  // Shared function, clock pin
  input  wire logic                   PIN_CLK_OE,   // Shared function enable
  pmt_link_if.device                  LINK          // Serial link
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage and pin synchronisers

  pmt_word_t                    mem [`PMT_DEPTH];
  logic [`PMT_SYNC_W-1:0]       sync1_r;
  logic [`PMT_SYNC_W-1:0]       sync2_r;
  logic                         clk_d_r;
  logic                         s_clk;
  logic                         s_data;
  logic                         s_entry;
  logic                         s_emu;
  logic                         rise;

  // Pins come from another domain, so two flops before use
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
      clk_d_r <= 1'b0;
    end
    else
    begin
      sync1_r <= {LINK.prog_serial_clock, LINK.prog_serial_data,
                  LINK.host_entry, EMU_MODE};
      sync2_r <= sync1_r;
      clk_d_r <= sync2_r[3];
    end
  end

  assign s_clk   = sync2_r[3];
  assign s_data  = sync2_r[2];
  assign s_entry = sync2_r[1];
  assign s_emu   = sync2_r[0];
  assign rise    = s_clk & ~clk_d_r & s_entry;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction fetch and reset vector

  pmt_word_t instr_nxt;
  logic      pc_load_nxt;
  logic      rst_seen_r;

  always_comb
  begin
    instr_nxt   = mem[CORE_PC];
    pc_load_nxt = ~rst_seen_r;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      INSTR      <= '0;
      PC_LOAD    <= 1'b0;
      PC_VECTOR  <= `PMT_RESET_VEC;
      rst_seen_r <= 1'b0;
    end
    else
    begin
      INSTR      <= instr_nxt;
      PC_LOAD    <= pc_load_nxt;
      PC_VECTOR  <= `PMT_RESET_VEC;
      rst_seen_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Table-read sequencer

  pmt_tbl_state_t          ts_r;
  pmt_tbl_state_t          ts_nxt;
  logic [`PMT_CNT_W-1:0]   cnt_r;
  logic [`PMT_CNT_W-1:0]   cnt_nxt;
  pmt_addr_t               taddr_r;
  pmt_addr_t               taddr_nxt;
  pmt_word_t               tword_r;
  pmt_word_t               tword_nxt;
  logic [`PMT_BYTE_W-1:0]  dest_nxt;
  logic                    busy_nxt;
  logic                    we_nxt;
  logic [`PMT_BYTE_W-1:0]  wdata_nxt;
  logic [`PMT_BYTE_W-1:0]  thigh_nxt;

  // Address never touches the PC; the last-page form fixes the top nibble
  always_comb
  begin
    ts_nxt    = ts_r;
    cnt_nxt   = cnt_r;
    taddr_nxt = taddr_r;
    tword_nxt = tword_r;
    dest_nxt  = DM_ADDR;
    busy_nxt  = TBL_BUSY;
    we_nxt    = 1'b0;
    wdata_nxt = DM_WDATA;
    thigh_nxt = TABLE_HIGH;
    unique case (ts_r)
      PMT_TS_IDLE:
      begin
        if (TBL_RD)
        begin
          taddr_nxt = TBL_LAST ? {`PMT_LAST_PAGE, TBLP}
                               : {TBHP, TBLP};
          dest_nxt  = TBL_DEST;
          busy_nxt  = 1'b1;
          cnt_nxt   = '0;
          ts_nxt    = PMT_TS_FETCH;
        end
      end
      PMT_TS_FETCH:
      begin
        tword_nxt = mem[taddr_r];
        cnt_nxt   = cnt_r + 1'b1;
        // Eight clocks of busy equal two instruction cycles
        if (cnt_r == `PMT_CNT_W'(`PMT_TBL_CLKS - 2))
        begin
          we_nxt    = 1'b1;
          wdata_nxt = tword_nxt[`PMT_BYTE_W-1:0];
          thigh_nxt = {1'b0, tword_nxt[`PMT_WORD_W-1:`PMT_BYTE_W]};
          ts_nxt    = PMT_TS_DONE;
        end
      end
      PMT_TS_DONE:
      begin
        busy_nxt = 1'b0;
        ts_nxt   = PMT_TS_IDLE;
      end
      default:
      begin
        busy_nxt = 1'b0;
        ts_nxt   = PMT_TS_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      ts_r       <= PMT_TS_IDLE;
      cnt_r      <= '0;
      taddr_r    <= '0;
      tword_r    <= '0;
      DM_ADDR    <= '0;
      TBL_BUSY   <= 1'b0;
      DM_WE      <= 1'b0;
      DM_WDATA   <= '0;
      TABLE_HIGH <= '0;
    end
    else
    begin
      ts_r       <= ts_nxt;
      cnt_r      <= cnt_nxt;
      taddr_r    <= taddr_nxt;
      tword_r    <= tword_nxt;
      DM_ADDR    <= dest_nxt;
      TBL_BUSY   <= busy_nxt;
      DM_WE      <= we_nxt;
      DM_WDATA   <= wdata_nxt;
      TABLE_HIGH <= thigh_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial programming slave and shared pin drive

  logic [`PMT_BIT_W-1:0]   bit_r;
  logic [`PMT_BIT_W-1:0]   bit_nxt;
  logic [`PMT_FRAME_BITS-1:0] rx_r;
  logic [`PMT_FRAME_BITS-1:0] rx_nxt;
  logic [`PMT_ADDR_W:0]    hdr_r;
  logic [`PMT_ADDR_W:0]    hdr_nxt;
  pmt_word_t               tx_r;
  pmt_word_t               tx_nxt;
  logic                    txen_r;
  logic                    txen_nxt;
  logic                    mwe_r;
  logic                    mwe_nxt;
  pmt_addr_t               mwa_r;
  pmt_addr_t               mwa_nxt;
  pmt_word_t               mwd_r;
  pmt_word_t               mwd_nxt;
  logic                    dout_nxt;
  logic                    doe_nxt;
  logic                    cout_nxt;
  logic                    coe_nxt;

  // Bits are taken on each programmer clock rise; the read word leaves MSB first
  always_comb
  begin
    bit_nxt  = bit_r;
    rx_nxt   = rx_r;
    hdr_nxt  = hdr_r;
    tx_nxt   = tx_r;
    txen_nxt = txen_r;
    mwe_nxt  = 1'b0;
    mwa_nxt  = mwa_r;
    mwd_nxt  = mwd_r;
    if (!s_entry)
    begin
      bit_nxt  = '0;
      txen_nxt = 1'b0;
    end
    else if (rise)
    begin
      rx_nxt  = {rx_r[`PMT_FRAME_BITS-2:0], s_data};
      bit_nxt = bit_r + 1'b1;
      if (txen_r)
        tx_nxt = {tx_r[`PMT_WORD_W-2:0], 1'b0};
      if (bit_r == `PMT_HDR_LAST)
      begin
        hdr_nxt = rx_nxt[`PMT_ADDR_W:0];
        if (rx_nxt[`PMT_ADDR_W] != `PMT_CMD_WRITE)
        begin
          tx_nxt   = mem[rx_nxt[`PMT_ADDR_W-1:0]];
          txen_nxt = 1'b1;
        end
      end
      if (bit_r == `PMT_LAST_BIT)
      begin
        txen_nxt = 1'b0;
        bit_nxt  = '0;
        mwe_nxt  = (hdr_r[`PMT_ADDR_W] == `PMT_CMD_WRITE);
        mwa_nxt  = hdr_r[`PMT_ADDR_W-1:0];
        mwd_nxt  = rx_nxt[`PMT_WORD_W-1:0];
      end
    end
    // Shared functions lose the pins while programming or on the emulation part
    // Read data waits for the clock fall ending the header, when the programmer
    // lets go of the pin; driving at the rise would fight its last header bit
    dout_nxt = txen_nxt ? tx_nxt[`PMT_WORD_W-1] : PIN_DATA_OUT;
    doe_nxt  = (txen_nxt & ~(s_clk & (bit_nxt == `PMT_HDR_BITS)))
             | (PIN_DATA_OE & ~s_emu & ~s_entry);
    cout_nxt = PIN_CLK_OUT;
    coe_nxt  = PIN_CLK_OE & ~s_emu & ~s_entry;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      bit_r            <= '0;
      rx_r             <= '0;
      hdr_r            <= '0;
      tx_r             <= '0;
      txen_r           <= 1'b0;
      mwe_r            <= 1'b0;
      mwa_r            <= '0;
      mwd_r            <= '0;
      LINK.dev_data_o  <= 1'b0;
      LINK.dev_data_oe <= 1'b0;
      LINK.dev_clk_o   <= 1'b0;
      LINK.dev_clk_oe  <= 1'b0;
    end
    else
    begin
      bit_r            <= bit_nxt;
      rx_r             <= rx_nxt;
      hdr_r            <= hdr_nxt;
      tx_r             <= tx_nxt;
      txen_r           <= txen_nxt;
      mwe_r            <= mwe_nxt;
      mwa_r            <= mwa_nxt;
      mwd_r            <= mwd_nxt;
      LINK.dev_data_o  <= dout_nxt;
      LINK.dev_data_oe <= doe_nxt;
      LINK.dev_clk_o   <= cout_nxt;
      LINK.dev_clk_oe  <= coe_nxt;
    end
  end

  // Array write one clock after the frame ends; contents survive reset
  always_ff @(posedge CORE_CLK)
  begin
    if (mwe_r)
      mem[mwa_r] <= mwd_r;
  end

endmodule

`default_nettype wire

// ### rtl/pmt_programmer.sv
// External programmer end: frames word reads and writes on the serial link
`timescale 1ns/1ps
`default_nettype none
`include "pmt_defines.svh"

module pmt_programmer
  import pmt_pkg::*;
#(
  parameter int HALF_CLKS = `PMT_HALF_CLKS               // Clocks per half link period
)
(
  input  wire logic                   CORE_CLK,   // System clock
  input  wire logic                   RST,        // Synchronous reset, active high
  input  wire logic                   CMD_VALID,  // Command request
  input  wire logic                   CMD_WRITE,  // 1 write, 0 read
  input  wire logic [`PMT_ADDR_W-1:0] CMD_ADDR,   // Word address
  input  wire logic [`PMT_WORD_W-1:0] CMD_WDATA,  // Write data
  output var  logic                   CMD_READY,  // Idle, command accepted
  output var  logic                   RSP_VALID,  // Pulse: read data valid
  output var  logic [`PMT_WORD_W-1:0] RSP_DATA,   // Read data
  pmt_link_if.host                    LINK        // Serial link
);

  ////////////////////////////////////////////////////////////////////////////
  // Returned data synchroniser

  logic data_s1_r;
  logic data_s2_r;

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      data_s1_r <= 1'b1;
      data_s2_r <= 1'b1;
    end
    else
    begin
      data_s1_r <= LINK.prog_serial_data;
      data_s2_r <= data_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame sequencer; this end owns the link clock and divides it from CORE_CLK

  pmt_host_state_t            hs_r;
  pmt_host_state_t            hs_nxt;
  logic [`PMT_TMR_W-1:0]      tmr_r;
  logic [`PMT_TMR_W-1:0]      tmr_nxt;
  logic [`PMT_BIT_W-1:0]      bit_r;
  logic [`PMT_BIT_W-1:0]      bit_nxt;
  logic [`PMT_FRAME_BITS-1:0] fr_r;
  logic [`PMT_FRAME_BITS-1:0] fr_nxt;
  logic                       wr_r;
  logic                       wr_nxt;
  pmt_word_t                  rd_r;
  pmt_word_t                  rd_nxt;
  logic                       rdy_nxt;
  logic                       rv_nxt;
  logic                       do_nxt;
  logic                       doe_nxt;
  logic                       ck_nxt;
  logic                       en_nxt;
  logic                       tend;

  assign tend = (tmr_r == `PMT_TMR_W'(HALF_CLKS - 1));

  // Data is released after the header of a read so the device can answer
  always_comb
  begin
    hs_nxt  = hs_r;
    tmr_nxt = tend ? '0 : tmr_r + 1'b1;
    bit_nxt = bit_r;
    fr_nxt  = fr_r;
    wr_nxt  = wr_r;
    rd_nxt  = rd_r;
    rdy_nxt = CMD_READY;
    rv_nxt  = 1'b0;
    do_nxt  = LINK.host_data_o;
    doe_nxt = LINK.host_data_oe;
    ck_nxt  = LINK.host_clk_o;
    en_nxt  = LINK.host_entry;
    unique case (hs_r)
      PMT_HS_IDLE:
      begin
        tmr_nxt = '0;
        if (CMD_VALID)
        begin
          fr_nxt  = {CMD_WRITE, CMD_ADDR, (CMD_WRITE ? CMD_WDATA : pmt_word_t'(0))};
          wr_nxt  = CMD_WRITE;
          bit_nxt = '0;
          rdy_nxt = 1'b0;
          en_nxt  = 1'b1;
          do_nxt  = fr_nxt[`PMT_FRAME_BITS-1];
          doe_nxt = 1'b1;
          hs_nxt  = PMT_HS_LOW;
        end
      end
      PMT_HS_LOW:
      begin
        if (tend)
        begin
          ck_nxt = 1'b1;
          if (!wr_r && bit_r >= `PMT_HDR_BITS)
            rd_nxt = {rd_r[`PMT_WORD_W-2:0], data_s2_r};
          hs_nxt = PMT_HS_HIGH;
        end
      end
      PMT_HS_HIGH:
      begin
        if (tend)
        begin
          ck_nxt = 1'b0;
          if (bit_r == `PMT_LAST_BIT)
          begin
            en_nxt  = 1'b0;
            doe_nxt = 1'b0;
            hs_nxt  = PMT_HS_GAP;
          end
          else
          begin
            bit_nxt = bit_r + 1'b1;
            fr_nxt  = {fr_r[`PMT_FRAME_BITS-2:0], 1'b0};
            do_nxt  = fr_nxt[`PMT_FRAME_BITS-1];
            doe_nxt = wr_r | (bit_nxt < `PMT_HDR_BITS);
            hs_nxt  = PMT_HS_LOW;
          end
        end
      end
      PMT_HS_GAP:
      begin
        // Entry stays low long enough for the device to see the frame end
        if (tend)
        begin
          rv_nxt  = ~wr_r;
          rdy_nxt = 1'b1;
          hs_nxt  = PMT_HS_IDLE;
        end
      end
      default:
      begin
        hs_nxt = PMT_HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      hs_r              <= PMT_HS_IDLE;
      tmr_r             <= '0;
      bit_r             <= '0;
      fr_r              <= '0;
      wr_r              <= 1'b0;
      rd_r              <= '0;
      CMD_READY         <= 1'b1;
      RSP_VALID         <= 1'b0;
      RSP_DATA          <= '0;
      LINK.host_data_o  <= 1'b0;
      LINK.host_data_oe <= 1'b0;
      LINK.host_clk_o   <= 1'b0;
      LINK.host_clk_oe  <= 1'b0;
      LINK.host_entry   <= 1'b0;
    end
    else
    begin
      hs_r              <= hs_nxt;
      tmr_r             <= tmr_nxt;
      bit_r             <= bit_nxt;
      fr_r              <= fr_nxt;
      wr_r              <= wr_nxt;
      rd_r              <= rd_nxt;
      CMD_READY         <= rdy_nxt;
      RSP_VALID         <= rv_nxt;
      RSP_DATA          <= rv_nxt ? rd_r : RSP_DATA;
      LINK.host_data_o  <= do_nxt;
      LINK.host_data_oe <= doe_nxt;
      LINK.host_clk_o   <= ck_nxt;
      LINK.host_clk_oe  <= en_nxt;                       // Clock driven only in frames
      LINK.host_entry   <= en_nxt;
    end
  end

endmodule

`default_nettype wire

// ### tb/pmt_asserts.sv
// Concurrent checks on the table-read outputs and the shared serial link
`timescale 1ns/1ps
`default_nettype none
`include "pmt_defines.svh"

module pmt_asserts
(
  input wire logic                   CORE_CLK,    // System clock
  input wire logic                   RST,         // Synchronous reset
  input wire logic                   TBL_BUSY,    // Table read in progress
  input wire logic                   DM_WE,       // Data memory write pulse
  input wire logic [`PMT_BYTE_W-1:0] DM_ADDR,     // Data memory address
  input wire logic [`PMT_BYTE_W-1:0] TBL_DEST,    // Operand register address
  input wire logic [`PMT_BYTE_W-1:0] TABLE_HIGH,  // Table high latch
  input wire logic                   PC_LOAD,     // Start pulse
  input wire logic [`PMT_ADDR_W-1:0] PC_VECTOR,   // Start address
  input wire logic                   dev_data_oe, // Device drives data pin
  input wire logic                   dev_clk_oe,  // Device drives clock pin
  input wire logic                   host_data_oe // Programmer drives data pin
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);

  ////////////////////////////////////////////////////////////////////////////
  // Table read timing and results; a slip of one clock shows as a wrong length
  busy_len_a: assert property ($rose(TBL_BUSY) |-> TBL_BUSY[*8] ##1 !TBL_BUSY)
    else $error("table read busy length wrong");
  we_end_a: assert property (DM_WE |-> TBL_BUSY ##1 (!TBL_BUSY && !DM_WE))
    else $error("write pulse not at end of read");
  dest_addr_a: assert property (DM_WE |-> DM_ADDR == $past(TBL_DEST, 8))
    else $error("write address not the taken operand");
  high_zero_a: assert property (TABLE_HIGH[7] == 1'b0)
    else $error("unused latch bit not zero");
  high_hold_a: assert property (!DM_WE |-> $stable(TABLE_HIGH))
    else $error("latch changed without a table read");

  ////////////////////////////////////////////////////////////////////////////
  // Start vector after every reset
  start_load_a: assert property ($fell(RST) |=> PC_LOAD ##1 !PC_LOAD)
    else $error("no single start pulse after reset");
  start_vec_a: assert property (PC_LOAD |-> PC_VECTOR == 12'h000)
    else $error("start address not zero");

  ////////////////////////////////////////////////////////////////////////////
  // Link: clock belongs to the programmer, one data driver at a time
  clk_owner_a: assert property (!dev_clk_oe)
    else $error("device drives the link clock");
  one_driver_a: assert property (!(dev_data_oe && host_data_oe))
    else $error("both ends drive the data pin");

  cover property (DM_WE);
  cover property ($rose(dev_data_oe));
  cover property (PC_LOAD);
endmodule

`default_nettype wire

// ### tb/test_program_memory_table_read.sv
// Testbench joining the device and the programmer across the serial link
`timescale 1ns/1ps
`default_nettype none
`include "pmt_defines.svh"

module test_program_memory_table_read;
  import pmt_pkg::*;
  logic        clk, rst, tbl_rd, tbl_last, emu, pin_do, pin_doe, pin_co, pin_coe;
  logic        pc_load, tbl_busy, dm_we, cmd_valid, cmd_write, cmd_ready, rsp_valid;
  logic [11:0] core_pc, pc_vector, cmd_addr;
  logic [7:0]  tblp, tbl_dest, dm_addr, dm_wdata, table_high;
  logic [3:0]  tbhp;
  pmt_word_t   instr, cmd_wdata, rsp_data;
  int          err_count, checked, n;
  pmt_addr_t   a [4] = '{12'h000, 12'h306, 12'hf06, 12'hfff};
  pmt_word_t   d [4] = '{15'h0155, 15'h4c3c, 15'h7a1a, 15'h7fff};

  pmt_link_if link();

  pmt_device pmt_device_i (.CORE_CLK(clk), .RST(rst), .CORE_PC(core_pc), .INSTR(instr),
    .PC_LOAD(pc_load), .PC_VECTOR(pc_vector), .TBL_RD(tbl_rd), .TBL_LAST(tbl_last),
    .TBLP(tblp), .TBHP(tbhp), .TBL_DEST(tbl_dest), .TBL_BUSY(tbl_busy), .DM_WE(dm_we),
    .DM_ADDR(dm_addr), .DM_WDATA(dm_wdata), .TABLE_HIGH(table_high), .EMU_MODE(emu),
    .PIN_DATA_OUT(pin_do), .PIN_DATA_OE(pin_doe), .PIN_CLK_OUT(pin_co),
    .PIN_CLK_OE(pin_coe), .LINK(link));

  // Shorter link period keeps frames near 350 clocks
  pmt_programmer #(.HALF_CLKS(6)) pmt_programmer_i (.CORE_CLK(clk), .RST(rst),
    .CMD_VALID(cmd_valid), .CMD_WRITE(cmd_write), .CMD_ADDR(cmd_addr),
    .CMD_WDATA(cmd_wdata), .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid),
    .RSP_DATA(rsp_data), .LINK(link));

  pmt_asserts pmt_asserts_i (.CORE_CLK(clk), .RST(rst), .TBL_BUSY(tbl_busy), .DM_WE(dm_we),
    .DM_ADDR(dm_addr), .TBL_DEST(tbl_dest), .TABLE_HIGH(table_high), .PC_LOAD(pc_load),
    .PC_VECTOR(pc_vector), .dev_data_oe(link.dev_data_oe), .dev_clk_oe(link.dev_clk_oe),
    .host_data_oe(link.host_data_oe));

  //////////////////////////////////////////////////////////////////////////////
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Helpers: compare, verdict, one clock step, bounded wait
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      err_count++;
    end
  endtask

  task automatic tally_and_finish;
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic tick;
    @(posedge clk);
    #1;
  endtask

  // Inputs move 1 ns after the edge so the design never races the bench
  task automatic wait_for(ref logic sig, input logic lvl, output int cnt);
    cnt = 0;
    while (sig !== lvl && cnt < 1000)
    begin
      tick();
      cnt++;
    end
    if (cnt == 1000)
    begin
      err_count++;
      tally_and_finish();
    end
  endtask

  // One programmer command; a read compares the returned word
  task automatic prog(input logic w, input pmt_addr_t ad, input pmt_word_t wd);
    wait_for(cmd_ready, 1'b1, n);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_addr  = ad;
    cmd_wdata = wd;
    tick();
    cmd_valid = 1'b0;
    tick();
    if (!w)
    begin
      wait_for(rsp_valid, 1'b1, n);
      chk(rsp_data, wd);
    end
    wait_for(cmd_ready, 1'b1, n);
    repeat (8) tick();
  endtask

  // One table read; checks length, operand byte and latch contents
  task automatic tbl(input logic l, input logic [3:0] hp, input logic [7:0] lp,
                     input logic [7:0] dst, input pmt_word_t w);
    wait_for(tbl_busy, 1'b0, n);
    tbl_rd   = 1'b1;
    tbl_last = l;
    tbhp     = hp;
    tblp     = lp;
    tbl_dest = dst;
    tick();
    tbl_rd = 1'b0;
    tbhp   = ~hp;
    wait_for(dm_we, 1'b1, n);
    // The pulse launched at the seventh edge is sampled by the core at the eighth
    chk(16'(n + 1), 16'(`PMT_TBL_CLKS));
    chk(tbl_busy, 1'b1);
    chk(dm_addr, dst);
    chk(dm_wdata, w[7:0]);
    chk(table_high, {1'b0, w[14:8]});
    tick();
    chk(tbl_busy, 1'b0);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {rst, tbl_rd, tbl_last, emu, pin_do, pin_doe, pin_co, pin_coe} = 8'h80;
    {cmd_valid, cmd_write, core_pc, tblp, tbhp, tbl_dest} = '0;
    {cmd_addr, cmd_wdata} = '0;
    err_count = 0;
    checked = 0;
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    tick();
    chk(pc_load, 1'b1);
    chk(pc_vector, 12'h000);
    for (int i = 0; i < 4; i++)
      prog(1'b1, a[i], d[i]);
    prog(1'b0, a[1], d[1]);
    for (int i = 0; i < 4; i++)
    begin
      core_pc = a[i];
      tick();
      chk(instr, d[i]);
    end
    // Back-to-back reads; the last-page one gets a wrong high pointer
    tbl(1'b0, 4'h3, 8'h06, 8'h21, d[1]);
    tbl(1'b1, 4'h3, 8'h06, 8'ha5, d[2]);
    tbl(1'b0, 4'hf, 8'hff, 8'h00, d[3]);
    repeat (20) tick();
    chk(table_high, {1'b0, d[3][14:8]});
    // Shared pin function drives low unless the emulation strap is set
    pin_doe = 1'b1;
    repeat (4) tick();
    chk(link.prog_serial_data, 1'b0);
    emu = 1'b1;
    repeat (4) tick();
    chk(link.prog_serial_data, 1'b1);
    prog(1'b1, 12'h0a0, 15'h2468);
    prog(1'b0, 12'h0a0, 15'h2468);
    {emu, pin_doe} = 2'b00;
    // Second reset: start again at zero, memory kept
    rst = 1'b1;
    repeat (3) tick();
    rst = 1'b0;
    tick();
    chk(pc_load, 1'b1);
    tbl(1'b0, 4'h0, 8'h00, 8'h10, d[0]);
    tally_and_finish();
  end
endmodule

`default_nettype wire
